// File: ucri_pkg.sv
// Constants shared by the serial transceiver register interface.
// Assumes a 32-bit APB slave port with 12 bits of byte address.
package ucri_pkg;
    localparam logic [11:0] OFF_COMMAND_STROBE = 12'h000;
    localparam logic [11:0] OFF_MODE_CONFIG = 12'h004;
    localparam logic [11:0] OFF_IRQ_ENABLE_SET = 12'h008;
    localparam logic [11:0] OFF_IRQ_DISABLE_CLEAR = 12'h00C;
    localparam logic [11:0] OFF_IRQ_MASK_VIEW = 12'h010;
    localparam logic [11:0] OFF_CHANNEL_STATE = 12'h014;
    localparam logic [11:0] OFF_RECEIVE_HOLDING = 12'h018;
    localparam logic [11:0] OFF_TRANSMIT_HOLDING = 12'h01C;
    localparam logic [11:0] OFF_BAUD_GENERATOR = 12'h020;
    localparam logic [11:0] OFF_RECEIVE_TIMEOUT = 12'h024;
    localparam logic [11:0] OFF_TRANSMIT_TIMEGUARD = 12'h028;
    localparam logic [11:0] OFF_SMARTCARD_RATE_RATIO = 12'h040;
    localparam logic [11:0] OFF_ERROR_COUNT = 12'h044;
    localparam logic [11:0] OFF_INFRARED_FILTER = 12'h04C;
    localparam logic [11:0] OFF_MANCHESTER_CONFIG = 12'h050;
    localparam logic [11:0] OFF_WRITE_PROTECT_MODE = 12'h0E4;
    localparam logic [11:0] OFF_WRITE_PROTECT_STATUS = 12'h0E8;
    localparam logic [11:0] OFF_DMA_FIRST = 12'h100;
    localparam logic [11:0] OFF_DMA_LAST = 12'h128;

    // Command strobe bit positions
    localparam int CMD_RX_RESET = 2;
    localparam int CMD_TX_RESET = 3;
    localparam int CMD_RX_ENABLE = 4;
    localparam int CMD_RX_DISABLE = 5;
    localparam int CMD_TX_ENABLE = 6;
    localparam int CMD_TX_DISABLE = 7;
    localparam int CMD_STATUS_CLEAR = 8;
    localparam int CMD_BREAK_BEGIN = 9;
    localparam int CMD_BREAK_END = 10;
    localparam int CMD_TIMEOUT_ARM = 11;
    localparam int CMD_ADDRESS_CHAR = 12;
    localparam int CMD_ITERATION_CLEAR = 13;
    localparam int CMD_NACK_CLEAR = 14;
    localparam int CMD_TIMEOUT_RESTART = 15;
    localparam int CMD_LINE_ASSERT = 18;
    localparam int CMD_LINE_DEASSERT = 19;

    // Mode configuration fields
    localparam int MODE_LSB = 0;
    localparam int CHRL_LSB = 6;
    localparam int PAR_LSB = 9;
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_ISO_T0 = 4'h4;
    localparam logic [3:0] MODE_ISO_T1 = 4'h6;
    localparam logic [3:0] MODE_SPI_MASTER = 4'hE;
    localparam logic [3:0] MODE_SPI_SLAVE = 4'hF;
    localparam logic [2:0] PAR_MULTIDROP = 3'h6;

    // Channel state bit positions
    localparam int ST_PARITY = 0;
    localparam int ST_FRAMING = 1;
    localparam int ST_OVERRUN = 2;
    localparam int ST_UNDERRUN = 3;
    localparam int ST_MANCHESTER = 4;
    localparam int ST_BREAK_RX = 5;
    localparam int ST_TIMEOUT = 6;
    localparam int ST_ITERATION = 7;
    localparam int ST_NACK = 8;
    localparam int ST_BREAK_ACTIVE = 9;
    localparam int ST_RX_ENABLED = 10;
    localparam int ST_TX_ENABLED = 11;
    localparam int ST_W = 12;

    localparam int WP_ENABLE_BIT = 0;
    localparam int WP_SOURCE_LSB = 8;
    localparam logic [31:0] RATE_RATIO_RESET = 32'h00000174;
    localparam logic [3:0] CHAR_MIN_BITS = 4'h5;
    localparam logic [3:0] CHAR_FRAME_BITS = 4'h2;
    localparam logic [3:0] BREAK_MARK_BITS = 4'hC;

    typedef enum logic [2:0] {BRK_NONE, BRK_WAIT_EMPTY, BRK_ACTIVE, BRK_END_PEND, BRK_MARK} ucri_brk_type;
    typedef enum logic [1:0] {TO_IDLE, TO_WAIT_CHAR, TO_RUN} ucri_to_type;
endpackage

// File: ucri_cfg_mem.sv
// Small word store for configuration registers that only software uses.
// Assumes one write port and one registered read port on the same clock.
`timescale 1ns/1ps
module ucri_cfg_mem #(
    parameter int DEPTH = 8,
    parameter int AW = 3,
    parameter int RATIO_SLOT = 2
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic [AW-1:0] rd_idx,
    output logic [31:0] rd_data
);
    logic [31:0] mem [DEPTH];

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= (i == RATIO_SLOT) ? ucri_pkg::RATE_RATIO_RESET : 32'h00000000;
            end
        end else if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rd_data <= 32'h00000000;
        end else begin
            rd_data <= mem[rd_idx];
        end
    end
endmodule

// File: ucri_regs.sv
// APB register interface and command decoder of a multi-mode serial transceiver.
// Assumes the serial paths report events as one-cycle pulses and a bit tick.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module ucri_regs #(
    parameter int TO_W = 16
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic BIT_TICK,
    input wire logic TX_IDLE,
    input wire logic TX_CHAR_LOAD,
    input wire logic RX_CHAR_DONE,
    input wire logic [8:0] RX_DATA,
    input wire logic [7:0] ERROR_TOTAL,
    input wire logic RX_PARITY_ERR,
    input wire logic RX_FRAME_ERR,
    input wire logic RX_OVERRUN,
    input wire logic TX_UNDERRUN,
    input wire logic RX_MANCHESTER_ERR,
    input wire logic RX_BREAK_SEEN,
    input wire logic ISO_ITERATION_LIMIT_FLAG_LIMIT,
    input wire logic ISO_NACK_SEEN,
    output logic RX_ENABLE,
    output logic TX_ENABLE,
    output logic RX_RESET,
    output logic TX_RESET,
    output logic TX_BREAK,
    output logic TX_MARK_HOLD,
    output logic TX_ADDRESS_BIT,
    output logic [8:0] TX_DATA,
    output logic TX_DATA_WRITE,
    output logic REQUEST_LINE
);
    logic access_done;
    logic wr_done;
    logic rd_done;
    logic cmd_wr;
    logic blocked;
    logic [31:0] mode_config;
    logic [31:0] receive_timeout;
    logic [31:0] irq_mask;
    logic wp_enable;
    logic wp_flag;
    logic [11:0] wp_source;
    localparam int ST_W = ucri_pkg::ST_W;
    logic [ST_W-1:0] status;
    logic [31:0] mem_rdata;
    logic [3:0] slot;
    logic [3:0] mode;
    logic spi;
    logic iso;
    logic [3:0] bit_count;
    logic [3:0] char_len;
    logic [TO_W-1:0] to_count;
    ucri_pkg::ucri_brk_type brk_state;
    ucri_pkg::ucri_brk_type next_brk;
    ucri_pkg::ucri_to_type to_state;

    function automatic logic [3:0] cfg_slot(input logic [11:0] addr);
        case (addr)
            ucri_pkg::OFF_BAUD_GENERATOR: cfg_slot = 4'h8;
            ucri_pkg::OFF_TRANSMIT_TIMEGUARD: cfg_slot = 4'h9;
            ucri_pkg::OFF_SMARTCARD_RATE_RATIO: cfg_slot = 4'hA;
            ucri_pkg::OFF_INFRARED_FILTER: cfg_slot = 4'hB;
            ucri_pkg::OFF_MANCHESTER_CONFIG: cfg_slot = 4'hC;
            default: cfg_slot = 4'h0;
        endcase
    endfunction

    function automatic logic is_spi(input logic [3:0] m);
        is_spi = (m == ucri_pkg::MODE_SPI_MASTER) || (m == ucri_pkg::MODE_SPI_SLAVE);
    endfunction

    assign access_done = PSEL && PENABLE && PREADY;
    assign wr_done = access_done && PWRITE;
    assign rd_done = access_done && !PWRITE;
    assign mode = mode_config[ucri_pkg::MODE_LSB +: 4];
    assign spi = is_spi(mode);
    assign iso = (mode == ucri_pkg::MODE_ISO_T0) || (mode == ucri_pkg::MODE_ISO_T1);
    assign slot = cfg_slot(PADDR);
    // Protected set: mode, time-out and every word of the small store
    assign blocked = wp_enable && (PADDR == ucri_pkg::OFF_MODE_CONFIG
        || PADDR == ucri_pkg::OFF_RECEIVE_TIMEOUT || slot[3]);
    assign cmd_wr = wr_done && PADDR == ucri_pkg::OFF_COMMAND_STROBE;
    assign char_len = ucri_pkg::CHAR_MIN_BITS + {2'b00, mode_config[ucri_pkg::CHRL_LSB +: 2]}
        + ucri_pkg::CHAR_FRAME_BITS;

    // One wait state gives the store time to present its registered word
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end else begin
            PREADY <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && PADDR > ucri_pkg::OFF_DMA_LAST;
            if (PSEL && PENABLE && !PREADY) begin
                PRDATA <= 32'h00000000;
                if (!PWRITE) begin
                    case (PADDR)
                        ucri_pkg::OFF_MODE_CONFIG: PRDATA <= mode_config;
                        ucri_pkg::OFF_IRQ_MASK_VIEW: PRDATA <= irq_mask;
                        ucri_pkg::OFF_CHANNEL_STATE: PRDATA <= {{(32-ST_W){1'b0}}, status};
                        ucri_pkg::OFF_RECEIVE_HOLDING: PRDATA <= {23'h0, RX_DATA};
                        ucri_pkg::OFF_RECEIVE_TIMEOUT: PRDATA <= receive_timeout;
                        ucri_pkg::OFF_ERROR_COUNT: PRDATA <= {24'h000000, ERROR_TOTAL};
                        ucri_pkg::OFF_WRITE_PROTECT_MODE: PRDATA <= {31'h0, wp_enable};
                        ucri_pkg::OFF_WRITE_PROTECT_STATUS: PRDATA <= {12'h000, wp_source, 7'h00, wp_flag};
                        default: PRDATA <= slot[3] ? mem_rdata : 32'h00000000;
                    endcase
                end
            end
        end
    end

    ucri_cfg_mem #(.DEPTH(8), .AW(3), .RATIO_SLOT(2)) u_cfg (
        .CLOCK(CLOCK),
        .RST(RST),
        .wr_en(wr_done && slot[3] && !blocked),
        .wr_idx(slot[2:0]),
        .wr_data(PWDATA),
        .rd_idx(slot[2:0]),
        .rd_data(mem_rdata)
    );

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            mode_config <= 32'h00000000;
            receive_timeout <= 32'h00000000;
            irq_mask <= 32'h00000000;
            wp_enable <= 1'b0;
        end else if (wr_done) begin
            if (PADDR == ucri_pkg::OFF_MODE_CONFIG && !blocked) mode_config <= PWDATA;
            if (PADDR == ucri_pkg::OFF_RECEIVE_TIMEOUT && !blocked) receive_timeout <= PWDATA;
            if (PADDR == ucri_pkg::OFF_IRQ_ENABLE_SET) irq_mask <= irq_mask | PWDATA;
            if (PADDR == ucri_pkg::OFF_IRQ_DISABLE_CLEAR) irq_mask <= irq_mask & ~PWDATA;
            if (PADDR == ucri_pkg::OFF_WRITE_PROTECT_MODE) wp_enable <= PWDATA[ucri_pkg::WP_ENABLE_BIT];
        end
    end

    // Violation flag: a new violation wins over the clearing read
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            wp_flag <= 1'b0;
            wp_source <= 12'h000;
        end else if (wr_done && blocked) begin
            wp_flag <= 1'b1;
            wp_source <= PADDR;
        end else if (rd_done && PADDR == ucri_pkg::OFF_WRITE_PROTECT_STATUS) begin
            wp_flag <= 1'b0;
        end
    end

    // Enables: a disable bit always beats an enable bit in the same write
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            RX_ENABLE <= 1'b0;
            TX_ENABLE <= 1'b0;
        end else if (cmd_wr) begin
            if (PWDATA[ucri_pkg::CMD_RX_DISABLE]) RX_ENABLE <= 1'b0;
            else if (PWDATA[ucri_pkg::CMD_RX_ENABLE]) RX_ENABLE <= 1'b1;
            if (PWDATA[ucri_pkg::CMD_TX_DISABLE]) TX_ENABLE <= 1'b0;
            else if (PWDATA[ucri_pkg::CMD_TX_ENABLE]) TX_ENABLE <= 1'b1;
        end
    end

    // Pulses plus the held TX_DATA word; the command word itself is never stored
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            RX_RESET <= 1'b0;
            TX_RESET <= 1'b0;
            TX_DATA_WRITE <= 1'b0;
            TX_DATA <= 9'h000;
        end else begin
            RX_RESET <= cmd_wr && PWDATA[ucri_pkg::CMD_RX_RESET];
            TX_RESET <= cmd_wr && PWDATA[ucri_pkg::CMD_TX_RESET];
            TX_DATA_WRITE <= wr_done && PADDR == ucri_pkg::OFF_TRANSMIT_HOLDING;
            if (wr_done && PADDR == ucri_pkg::OFF_TRANSMIT_HOLDING) TX_DATA <= PWDATA[8:0];
        end
    end

    // Status flags: a hardware event in the clearing cycle wins
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            status[ST_W-1:0] <= '0;
        end else begin
            if (cmd_wr && PWDATA[ucri_pkg::CMD_STATUS_CLEAR]) begin
                status[ucri_pkg::ST_OVERRUN] <= 1'b0;
                if (spi) status[ucri_pkg::ST_UNDERRUN] <= 1'b0;
                else begin
                    status[ucri_pkg::ST_PARITY] <= 1'b0;
                    status[ucri_pkg::ST_FRAMING] <= 1'b0;
                    status[ucri_pkg::ST_MANCHESTER] <= 1'b0;
                    status[ucri_pkg::ST_BREAK_RX] <= 1'b0;
                end
            end
            if (cmd_wr && !spi && PWDATA[ucri_pkg::CMD_TIMEOUT_ARM]) status[ucri_pkg::ST_TIMEOUT] <= 1'b0;
            if (cmd_wr && !spi && iso && PWDATA[ucri_pkg::CMD_ITERATION_CLEAR]) begin
                status[ucri_pkg::ST_ITERATION] <= 1'b0;
            end
            if (cmd_wr && !spi && PWDATA[ucri_pkg::CMD_NACK_CLEAR]) status[ucri_pkg::ST_NACK] <= 1'b0;
            if (RX_PARITY_ERR) status[ucri_pkg::ST_PARITY] <= 1'b1;
            if (RX_FRAME_ERR) status[ucri_pkg::ST_FRAMING] <= 1'b1;
            if (RX_OVERRUN) status[ucri_pkg::ST_OVERRUN] <= 1'b1;
            if (TX_UNDERRUN) status[ucri_pkg::ST_UNDERRUN] <= 1'b1;
            if (RX_MANCHESTER_ERR) status[ucri_pkg::ST_MANCHESTER] <= 1'b1;
            if (RX_BREAK_SEEN) status[ucri_pkg::ST_BREAK_RX] <= 1'b1;
            if (to_state == ucri_pkg::TO_RUN && BIT_TICK && to_count == receive_timeout[TO_W-1:0] - 1'b1) begin
                status[ucri_pkg::ST_TIMEOUT] <= 1'b1;
            end
            if (ISO_ITERATION_LIMIT_FLAG_LIMIT) status[ucri_pkg::ST_ITERATION] <= 1'b1;
            if (ISO_NACK_SEEN) status[ucri_pkg::ST_NACK] <= 1'b1;
            status[ucri_pkg::ST_BREAK_ACTIVE] <= TX_BREAK;
            status[ucri_pkg::ST_RX_ENABLED] <= RX_ENABLE;
            status[ucri_pkg::ST_TX_ENABLED] <= TX_ENABLE;
        end
    end

    // Break sequencer, counted in bit periods
    always_comb begin
        next_brk = brk_state;
        case (brk_state)
            ucri_pkg::BRK_NONE: begin
                if (cmd_wr && !spi && PWDATA[ucri_pkg::CMD_BREAK_BEGIN]) next_brk = ucri_pkg::BRK_WAIT_EMPTY;
            end
            ucri_pkg::BRK_WAIT_EMPTY: begin
                if (TX_IDLE) next_brk = ucri_pkg::BRK_ACTIVE;
            end
            ucri_pkg::BRK_ACTIVE: begin
                if (cmd_wr && !spi && PWDATA[ucri_pkg::CMD_BREAK_END]) next_brk = ucri_pkg::BRK_END_PEND;
            end
            ucri_pkg::BRK_END_PEND: begin
                if (bit_count >= char_len) next_brk = ucri_pkg::BRK_MARK;
            end
            ucri_pkg::BRK_MARK: begin
                if (BIT_TICK && bit_count == ucri_pkg::BREAK_MARK_BITS - 4'h1) next_brk = ucri_pkg::BRK_NONE;
            end
            default: next_brk = ucri_pkg::BRK_NONE;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST || TX_RESET) begin
            brk_state <= ucri_pkg::BRK_NONE;
            bit_count <= 4'h0;
            TX_BREAK <= 1'b0;
            TX_MARK_HOLD <= 1'b0;
        end else begin
            brk_state <= next_brk;
            TX_BREAK <= next_brk == ucri_pkg::BRK_ACTIVE || next_brk == ucri_pkg::BRK_END_PEND;
            TX_MARK_HOLD <= next_brk == ucri_pkg::BRK_MARK;
            if (next_brk != brk_state && next_brk != ucri_pkg::BRK_END_PEND) bit_count <= 4'h0;
            else if (BIT_TICK && bit_count != 4'hF) bit_count <= bit_count + 4'h1;
        end
    end

    // Receive time-out: the arm command wins over a restart in the same write
    always_ff @(posedge CLOCK) begin
        if (RST || RX_RESET) begin
            to_state <= ucri_pkg::TO_IDLE;
            to_count <= '0;
        end else if (cmd_wr && !spi && PWDATA[ucri_pkg::CMD_TIMEOUT_ARM]) begin
            to_state <= ucri_pkg::TO_WAIT_CHAR;
            to_count <= '0;
        end else if (cmd_wr && !spi && PWDATA[ucri_pkg::CMD_TIMEOUT_RESTART]) begin
            to_state <= ucri_pkg::TO_RUN;
            to_count <= '0;
        end else if (receive_timeout[TO_W-1:0] == '0) begin
            to_state <= ucri_pkg::TO_IDLE;
        end else if (RX_CHAR_DONE) begin
            to_state <= ucri_pkg::TO_RUN;
            to_count <= '0;
        end else if (to_state == ucri_pkg::TO_RUN && BIT_TICK) begin
            if (to_count == receive_timeout[TO_W-1:0] - 1'b1) to_state <= ucri_pkg::TO_IDLE;
            to_count <= to_count + 1'b1;
        end
    end

    // Address marker waits for the next character taken by the transmitter
    always_ff @(posedge CLOCK) begin
        if (RST || TX_RESET) begin
            TX_ADDRESS_BIT <= 1'b0;
        end else if (cmd_wr && !spi && PWDATA[ucri_pkg::CMD_ADDRESS_CHAR]
            && mode_config[ucri_pkg::PAR_LSB +: 3] == ucri_pkg::PAR_MULTIDROP) begin
            TX_ADDRESS_BIT <= 1'b1;
        end else if (TX_CHAR_LOAD) begin
            TX_ADDRESS_BIT <= 1'b0;
        end
    end

    // One pin serves request-to-send and SPI slave select; idles high
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            REQUEST_LINE <= 1'b1;
        end else if (cmd_wr && (mode == ucri_pkg::MODE_NORMAL || mode == ucri_pkg::MODE_SPI_MASTER)) begin
            if (PWDATA[ucri_pkg::CMD_LINE_ASSERT]) REQUEST_LINE <= 1'b0;
            else if (PWDATA[ucri_pkg::CMD_LINE_DEASSERT]) REQUEST_LINE <= 1'b1;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence arm_cmd;
        cmd_wr && !spi && PWDATA[ucri_pkg::CMD_TIMEOUT_ARM];
    endsequence

    chk_rx_reset_pulse: assert property (cmd_wr && PWDATA[ucri_pkg::CMD_RX_RESET] |=> RX_RESET ##1 !RX_RESET)
        else $error("receiver reset pulse wrong");
    chk_rx_disable_wins: assert property (cmd_wr && PWDATA[ucri_pkg::CMD_RX_DISABLE] |=> !RX_ENABLE)
        else $error("receiver disable lost");
    chk_tx_enable_sets: assert property (cmd_wr && PWDATA[ucri_pkg::CMD_TX_ENABLE]
        && !PWDATA[ucri_pkg::CMD_TX_DISABLE] |=> TX_ENABLE)
        else $error("transmitter enable lost");
    chk_parity_clear: assert property (cmd_wr && !spi && PWDATA[ucri_pkg::CMD_STATUS_CLEAR] && !RX_PARITY_ERR
        |=> !status[ucri_pkg::ST_PARITY])
        else $error("parity flag not cleared");
    chk_break_after_empty: assert property ($rose(TX_BREAK) |-> $past(TX_IDLE))
        else $error("break began before transmitter empty");
    chk_break_then_mark: assert property ($fell(TX_BREAK) && !$past(TX_RESET) |-> TX_MARK_HOLD)
        else $error("break end without mark period");
    chk_arm_waits: assert property ((arm_cmd and !RX_RESET) |=> to_state == ucri_pkg::TO_WAIT_CHAR
        && !status[ucri_pkg::ST_TIMEOUT])
        else $error("time-out arm failed");
    chk_request_assert: assert property (cmd_wr && mode == ucri_pkg::MODE_NORMAL
        && PWDATA[ucri_pkg::CMD_LINE_ASSERT] |=> !REQUEST_LINE)
        else $error("request line not driven low");
    chk_select_slave_off: assert property (mode == ucri_pkg::MODE_SPI_SLAVE && cmd_wr |=> $stable(REQUEST_LINE))
        else $error("select line moved in slave mode");
    chk_wp_blocks: assert property (wr_done && blocked |=> wp_flag && wp_source == $past(PADDR))
        else $error("protected write not flagged");
    chk_cmd_reads_zero: assert property (PSEL && PENABLE && !PREADY && !PWRITE
        && PADDR == ucri_pkg::OFF_COMMAND_STROBE |=> PRDATA == 32'h00000000)
        else $error("command location read nonzero");
endmodule

// File: ucri_peer.sv
// Far-side serial path model: bit tick, transmitter idle and load strobe.
// Assumes one character keeps the transmitter busy for 20 cycles.
`timescale 1ns/1ps
module ucri_peer (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic TX_DATA_WRITE,
    output logic BIT_TICK,
    output logic TX_IDLE,
    output logic TX_CHAR_LOAD
);
    logic [1:0] div;
    logic [4:0] busy;
    always_ff @(posedge CLOCK) begin
        div <= RST ? 2'h0 : div + 2'h1;
    end
    always_ff @(posedge CLOCK) begin
        if (RST)
            busy <= 5'h00;
        else if (TX_DATA_WRITE)
            busy <= 5'h14;
        else if (busy != 5'h00)
            busy <= busy - 5'h01;
    end
    assign BIT_TICK = div == 2'h3;
    // Busy window holds a pending break off the line
    assign TX_IDLE = busy == 5'h00 && !TX_DATA_WRITE;
    assign TX_CHAR_LOAD = TX_DATA_WRITE;
endmodule

// File: test_usart_command_register_interface.sv
// Bench for the register interface: APB command sequences with expected values.
// Assumes ucri_peer stands in for the serial paths.
`timescale 1ns/1ps
module test_usart_command_register_interface;
    logic clk, rst, psel, pen, pw, tick, idle, ld, txw, rdy, err, er, rcd;
    logic rxe, txe, rxr, txr, brk, mark, ab, rl;
    logic [11:0] pa;
    logic [31:0] pwd, prd, rd;
    logic [7:0] ev;
    logic [8:0] txd;
    int fail_count, n_checks, n;
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    ucri_peer peer_u (.CLOCK(clk), .RST(rst), .TX_DATA_WRITE(txw), .BIT_TICK(tick), .TX_IDLE(idle),
        .TX_CHAR_LOAD(ld));
    ucri_regs dut_u (.CLOCK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pw), .PADDR(pa),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err), .BIT_TICK(tick), .TX_IDLE(idle),
        .TX_CHAR_LOAD(ld), .RX_CHAR_DONE(rcd), .RX_DATA(9'h0AB), .ERROR_TOTAL(8'h00),
        .RX_PARITY_ERR(ev[0]), .RX_FRAME_ERR(ev[1]), .RX_OVERRUN(ev[2]), .TX_UNDERRUN(ev[3]),
        .RX_MANCHESTER_ERR(ev[4]), .RX_BREAK_SEEN(ev[5]), .ISO_ITERATION_LIMIT_FLAG_LIMIT(ev[6]), .ISO_NACK_SEEN(ev[7]),
        .RX_ENABLE(rxe), .TX_ENABLE(txe), .RX_RESET(rxr), .TX_RESET(txr), .TX_BREAK(brk),
        .TX_MARK_HOLD(mark), .TX_ADDRESS_BIT(ab), .TX_DATA(txd), .TX_DATA_WRITE(txw), .REQUEST_LINE(rl));
    task results;
        if (fail_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pw <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 20 && rdy !== 1'b1; i++) @(posedge clk);
        rd = prd;
        er = err;
        psel <= 1'b0;
        pen <= 1'b0;
        if (i == 20) begin
            chk("pready", 1, 0);
            results();
        end
    endtask
    task cmd(input logic [31:0] v);
        apb(1'b1, ucri_pkg::OFF_COMMAND_STROBE, v);
        repeat (3) @(posedge clk);
    endtask
    function logic [31:0] c(input int b);
        return 32'h00000001 << b;
    endfunction
    task status(input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, ucri_pkg::OFF_CHANNEL_STATE, 32'h00000000);
        chk("status", e, rd & m);
    endtask
    task pulse_ev(input logic [7:0] v);
        ev <= v;
        @(posedge clk);
        ev <= 8'h00;
    endtask
    initial begin
        {rst, psel, pen, pw, pa, pwd, ev, rcd} = 57'h100000000000000;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("line reset", 1, rl);
        cmd(c(ucri_pkg::CMD_RX_ENABLE) | c(ucri_pkg::CMD_RX_DISABLE) | c(ucri_pkg::CMD_TX_ENABLE));
        chk("rx enable", 0, rxe);
        chk("tx enable", 1, txe);
        cmd(c(ucri_pkg::CMD_RX_ENABLE) | c(ucri_pkg::CMD_TX_ENABLE) | c(ucri_pkg::CMD_TX_DISABLE));
        status(32'h00000C00, 32'h00000400);
        apb(1'b1, ucri_pkg::OFF_COMMAND_STROBE, c(ucri_pkg::CMD_RX_RESET) | c(ucri_pkg::CMD_TX_RESET));
        n = 0;
        repeat (4) @(posedge clk) n += (rxr === 1'b1) + 4 * (txr === 1'b1);
        chk("reset pulses", 5, 32'(n));
        pulse_ev(8'hFF);
        cmd(c(ucri_pkg::CMD_STATUS_CLEAR));
        status(32'h000001BF, 32'h00000188);
        cmd(c(ucri_pkg::CMD_ITERATION_CLEAR) | c(ucri_pkg::CMD_NACK_CLEAR));
        status(32'h00000180, 32'h00000080);
        apb(1'b0, ucri_pkg::OFF_COMMAND_STROBE, 32'h00000000);
        chk("command read", 0, rd);
        apb(1'b0, ucri_pkg::OFF_DMA_FIRST, 32'h00000000);
        chk("dma read", 0, {rd[30:0], er});
        apb(1'b0, ucri_pkg::OFF_DMA_LAST + 12'h004, 32'h00000000);
        chk("slave error", 1, er);
        cmd(c(ucri_pkg::CMD_LINE_ASSERT));
        chk("line assert", 0, rl);
        cmd(c(ucri_pkg::CMD_LINE_DEASSERT));
        chk("line deassert", 1, rl);
        apb(1'b1, ucri_pkg::OFF_RECEIVE_TIMEOUT, 32'h00000008);
        cmd(c(ucri_pkg::CMD_TIMEOUT_RESTART));
        cmd(c(ucri_pkg::CMD_TIMEOUT_ARM));
        repeat (40) @(posedge clk);
        status(32'h00000040, 32'h00000000);
        rcd <= 1'b1;
        @(posedge clk);
        rcd <= 1'b0;
        repeat (40) @(posedge clk);
        status(32'h00000040, 32'h00000040);
        cmd(c(ucri_pkg::CMD_TIMEOUT_ARM));
        status(32'h00000040, 32'h00000000);
        cmd(c(ucri_pkg::CMD_TIMEOUT_RESTART));
        repeat (40) @(posedge clk);
        status(32'h00000040, 32'h00000040);
        apb(1'b1, ucri_pkg::OFF_TRANSMIT_HOLDING, 32'h00000055);
        cmd(c(ucri_pkg::CMD_BREAK_BEGIN));
        chk("break held off", {1'b0, 9'h055}, {brk, txd});
        for (n = 0; n < 50 && brk !== 1'b1; n++) @(posedge clk);
        chk("break on", 1, brk);
        cmd(c(ucri_pkg::CMD_BREAK_END));
        for (n = 0; n < 200 && mark !== 1'b1; n++) @(posedge clk);
        n = 0;
        repeat (200) @(posedge clk) if (mark === 1'b1 && tick === 1'b1) n++;
        chk("mark ticks", 12, {brk, 31'(n)});
        cmd(c(ucri_pkg::CMD_ADDRESS_CHAR));
        chk("address off", 0, ab);
        apb(1'b1, ucri_pkg::OFF_MODE_CONFIG, {20'h00000, ucri_pkg::PAR_MULTIDROP, 9'h000});
        cmd(c(ucri_pkg::CMD_ADDRESS_CHAR));
        chk("address on", 1, ab);
        apb(1'b1, ucri_pkg::OFF_TRANSMIT_HOLDING, 32'h000001AA);
        repeat (2) @(posedge clk);
        chk("address used", 0, ab);
        apb(1'b1, ucri_pkg::OFF_MODE_CONFIG, {28'h0000000, ucri_pkg::MODE_ISO_T0});
        cmd(c(ucri_pkg::CMD_ITERATION_CLEAR));
        status(32'h00000080, 32'h00000000);
        apb(1'b1, ucri_pkg::OFF_MODE_CONFIG, {28'h0000000, ucri_pkg::MODE_SPI_MASTER});
        cmd(c(ucri_pkg::CMD_LINE_ASSERT));
        chk("select force", 0, rl);
        cmd(c(ucri_pkg::CMD_LINE_DEASSERT));
        chk("select release", 1, rl);
        pulse_ev(8'h0D);
        cmd(c(ucri_pkg::CMD_STATUS_CLEAR));
        status(32'h0000000D, 32'h00000001);
        apb(1'b1, ucri_pkg::OFF_MODE_CONFIG, {28'h0000000, ucri_pkg::MODE_SPI_SLAVE});
        cmd(c(ucri_pkg::CMD_LINE_ASSERT));
        chk("slave select", 1, rl);
        apb(1'b1, ucri_pkg::OFF_WRITE_PROTECT_MODE, 32'h00000001);
        apb(1'b1, ucri_pkg::OFF_BAUD_GENERATOR, 32'h00001234);
        apb(1'b0, ucri_pkg::OFF_BAUD_GENERATOR, 32'h00000000);
        chk("baud blocked", 0, rd);
        apb(1'b0, ucri_pkg::OFF_WRITE_PROTECT_STATUS, 32'h00000000);
        chk("violation", {12'h000, ucri_pkg::OFF_BAUD_GENERATOR, 8'h01}, rd);
        apb(1'b0, ucri_pkg::OFF_WRITE_PROTECT_STATUS, 32'h00000000);
        chk("violation cleared", {12'h000, ucri_pkg::OFF_BAUD_GENERATOR, 8'h00}, rd);
        apb(1'b1, ucri_pkg::OFF_WRITE_PROTECT_MODE, 32'h00000000);
        apb(1'b1, ucri_pkg::OFF_BAUD_GENERATOR, 32'h00001234);
        apb(1'b0, ucri_pkg::OFF_BAUD_GENERATOR, 32'h00000000);
        chk("baud written", 32'h00001234, rd);
        apb(1'b0, ucri_pkg::OFF_SMARTCARD_RATE_RATIO, 32'h00000000);
        chk("ratio reset", ucri_pkg::RATE_RATIO_RESET, rd);
        results();
    end
endmodule
